// file: osic_edge.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser with synchronised level and edge pulses
module osic_edge
    import osic_pkg::*;
(
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset,
    // Pin level in
    input  wire logic i_pin,
    // Synced level and edges
    output logic      o_level,
    output logic      o_rise,
    output logic      o_fall
);
    logic meta_q, meta_d, sync_q, sync_d, last_q, last_d;

    // Next values; first stage feeds only the second
    always_comb begin
        meta_d = i_pin;
        sync_d = meta_q;
        last_d = sync_q;
    end

    // Idle bus is high, so reset to one to avoid a false edge
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            last_q <= 1'b1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            last_q <= last_d;
        end
    end

    assign o_level = sync_q;
    assign o_rise  = sync_q & ~last_q;
    assign o_fall  = ~sync_q & last_q;
endmodule // osic_edge
`default_nettype wire

// file: osic_host.sv
`timescale 1ns/1ps
`default_nettype none
// Bus master model; open drain, so it only ever pulls a line low
module osic_host
    import osic_pkg::*;
(
    // Clock
    input  wire logic i_clk,
    // Wired SDA level
    input  wire logic i_sda,
    // Pull-down enables
    output logic      o_scl_oe,
    output logic      o_sda_oe
);
    int         half = 18;
    logic [6:0] dev  = SLAVE_ADDR;
    // Released bus at time zero
    initial begin
        o_scl_oe = 1'b0;
        o_sda_oe = 1'b0;
    end
    // One level change, held for half a bus clock
    task automatic put(input logic c, input logic d);
        o_scl_oe <= c;
        o_sda_oe <= d;
        repeat (half) @(posedge i_clk);
    endtask
    // Start or repeated start: SDA falls while SCL is high
    task automatic start();
        put(1'b1, 1'b0);
        put(1'b0, 1'b0);
        put(1'b0, 1'b1);
        put(1'b1, 1'b1);
    endtask
    task automatic stop();
        put(1'b1, 1'b1);
        put(1'b0, 1'b1);
        put(1'b0, 1'b0);
    endtask
    // Data held past the SCL fall so the slave never sees a false start
    task automatic bit_x(input logic low, output logic seen);
        put(1'b1, low);
        put(1'b0, low);
        seen = i_sda;
        o_scl_oe <= 1'b1;
        repeat (4) @(posedge i_clk);
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(!b[i], s);
        bit_x(1'b0, s);
        ack = !s;
    endtask
    task automatic recv(output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(1'b0, b[i]);
        bit_x(1'b0, s);
    endtask
    // Write: address, pointer, data
    task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ack);
        logic a;
        start();
        send({dev, 1'b0}, ack);
        send(p, a);
        send(d, a);
        stop();
    endtask
    // Read: pointer, repeated start, one byte, NACK
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        logic a;
        start();
        send({dev, 1'b0}, a);
        send(p, a);
        start();
        send({dev, 1'b1}, a);
        recv(d);
        stop();
    endtask
endmodule // osic_host
`default_nettype wire

// file: osic_pkg.sv
`default_nettype none
package osic_pkg;
    localparam logic [6:0] SLAVE_ADDR    = 7'h13;
    localparam logic [7:0] REG_FIRST     = 8'h80;
    localparam logic [7:0] REG_LAST      = 8'h90;
    localparam logic [7:0] REG_CMD       = 8'h80;
    localparam logic [7:0] REG_AMB_HI    = 8'h85;
    localparam logic [7:0] REG_AMB_LO    = 8'h86;
    localparam logic [7:0] REG_NEAR_HI   = 8'h87;
    localparam logic [7:0] REG_NEAR_LO   = 8'h88;
    localparam int         NUM_REGS      = 17;
    localparam int         BIT_LOCK      = 7;
    localparam int         BIT_AMB_RDY   = 6;
    localparam int         BIT_NEAR_RDY  = 5;
    localparam int         BIT_AMB_SS    = 4;
    localparam int         BIT_NEAR_SS   = 3;
    localparam int         BIT_AMB_EN    = 2;
    localparam int         BIT_NEAR_EN   = 1;
    localparam int         BIT_SELF_EN   = 0;
    localparam logic [7:0] REG_RESET_VAL = 8'h00;
    localparam logic [3:0] SYNC_DEPTH    = 4'h2;
endpackage
`default_nettype wire

// file: osic_port.sv
`timescale 1ns/1ps
`default_nettype none
// Two-wire slave and command register; 250 MHz gives ~73 samples per HS bit
module osic_port
    import osic_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    // Serial bus pins (open drain, oe high pulls low)
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_sda,
    output logic             o_sda_oe,
    // Measurement engine side
    input  wire logic        i_amb_done,
    input  wire logic        i_near_done,
    input  wire logic [7:0]  i_rd_data,
    output logic [7:0]       o_reg_addr,
    output logic [7:0]       o_wr_data,
    output logic             o_wr_stb,
    output logic             o_rd_stb,
    output logic             o_amb_single_shot,
    output logic             o_near_single_shot,
    output logic             o_amb_periodic,
    output logic             o_near_periodic,
    output logic             o_self_timed
);
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WR_ACK,
                              ST_READ, ST_RD_ACK, ST_START} osic_state_e;

    logic scl, scl_rise, scl_fall, sda, sda_rise, sda_fall;
    logic start, stop;

    osic_edge u_scl (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_pin   (i_scl),
        .o_level (scl),
        .o_rise  (scl_rise),
        .o_fall  (scl_fall)
    );
    osic_edge u_sda (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_pin   (i_sda),
        .o_level (sda),
        .o_rise  (sda_rise),
        .o_fall  (sda_fall)
    );

    // Start and stop are data edges while the clock is high
    assign start = sda_fall & scl;
    assign stop  = sda_rise & scl;

    osic_state_e state_q, state_d;
    logic [7:0]  shift_q, shift_d;
    logic [2:0]  cnt_q, cnt_d;
    logic        rw_q, rw_d;         // Set for a read transfer
    logic        ptr_set_q, ptr_set_d; // Pointer byte already taken
    logic [7:0]  ptr_q, ptr_d;
    logic        drive_q, drive_d;   // Pull sda low
    logic [7:0]  wdat_q, wdat_d;
    logic        wstb_q, wstb_d, rstb_q, rstb_d;
    logic        amb_rdy_q, amb_rdy_d, near_rdy_q, near_rdy_d;
    logic [2:0]  ctl_q, ctl_d;       // Amb enable, near enable, self timed
    logic        amb_ss_q, amb_ss_d, near_ss_q, near_ss_d;
    logic        in_range, amb_clr, near_clr;
    logic [7:0]  cmd_view, rd_byte;

    assign in_range = (ptr_q >= REG_FIRST) && (ptr_q <= REG_LAST);
    // Clear ready on the read of a matching result register
    assign amb_clr  = rstb_q && (ptr_q == REG_AMB_HI || ptr_q == REG_AMB_LO);
    assign near_clr = rstb_q && (ptr_q == REG_NEAR_HI || ptr_q == REG_NEAR_LO);

    // Command register view: lock bit always one
    always_comb begin
        cmd_view               = 8'h00;
        cmd_view[BIT_LOCK]     = 1'b1;
        cmd_view[BIT_AMB_RDY]  = amb_rdy_q;
        cmd_view[BIT_NEAR_RDY] = near_rdy_q;
        cmd_view[BIT_AMB_SS]   = amb_ss_q;
        cmd_view[BIT_NEAR_SS]  = near_ss_q;
        cmd_view[BIT_AMB_EN]   = ctl_q[2];
        cmd_view[BIT_NEAR_EN]  = ctl_q[1];
        cmd_view[BIT_SELF_EN]  = ctl_q[0];
        rd_byte = (ptr_q == REG_CMD) ? cmd_view : (in_range ? i_rd_data : 8'hFF);
    end

    // Protocol and register next-state logic
    always_comb begin
        state_d    = state_q;
        shift_d    = shift_q;
        cnt_d      = cnt_q;
        rw_d       = rw_q;
        ptr_set_d  = ptr_set_q;
        ptr_d      = ptr_q;
        drive_d    = drive_q;
        wdat_d     = wdat_q;
        wstb_d     = 1'b0;
        rstb_d     = 1'b0;
        ctl_d      = ctl_q;
        amb_ss_d   = amb_ss_q;
        near_ss_d  = near_ss_q;
        // Set wins over a clear in the same cycle
        amb_rdy_d  = i_amb_done | (amb_rdy_q & ~amb_clr);
        near_rdy_d = i_near_done | (near_rdy_q & ~near_clr);
        // Single shots self-clear when their result lands
        if (i_amb_done) amb_ss_d = 1'b0;
        if (i_near_done) near_ss_d = 1'b0;
        if (start) begin
            state_d   = ST_START; // The SCL fall after start carries no bit
            cnt_d     = 3'h0;
            drive_d   = 1'b0;
            ptr_set_d = 1'b0;
        end else if (stop) begin
            state_d = ST_IDLE;
            drive_d = 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    drive_d = 1'b0;
                end
                ST_START: begin
                    if (scl_fall) state_d = ST_ADDR;
                end
                ST_ADDR, ST_WRITE: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda};
                    end
                    if (scl_fall) begin
                        cnt_d = cnt_q + 3'h1;
                        if (cnt_q == 3'h7) begin
                            state_d = (state_q == ST_ADDR) ? ST_ADDR_ACK : ST_WR_ACK;
                            if (state_q == ST_ADDR) begin
                                // Foreign address: stay off the bus
                                if (shift_q[7:1] == SLAVE_ADDR) begin
                                    drive_d = 1'b1;
                                    rw_d    = shift_q[0];
                                end else begin
                                    state_d = ST_IDLE;
                                end
                            end else begin
                                drive_d = 1'b1;
                                if (!ptr_set_q) begin
                                    ptr_d     = shift_q;
                                    ptr_set_d = 1'b1;
                                end else begin
                                    wdat_d = shift_q;
                                    wstb_d = in_range;
                                end
                            end
                        end
                    end
                end
                ST_ADDR_ACK, ST_WR_ACK: begin
                    if (scl_fall) begin
                        cnt_d = 3'h0;
                        if (state_q == ST_ADDR_ACK && rw_q) begin
                            state_d = ST_READ;
                            shift_d = rd_byte;
                            drive_d = ~rd_byte[7];
                            rstb_d  = 1'b1;
                        end else begin
                            state_d = ST_WRITE;
                            drive_d = 1'b0;
                        end
                    end
                end
                ST_READ: begin
                    if (scl_fall) begin
                        cnt_d = cnt_q + 3'h1;
                        if (cnt_q == 3'h7) begin
                            state_d = ST_RD_ACK;
                            drive_d = 1'b0;
                        end else begin
                            drive_d = ~shift_q[3'h6 - cnt_q];
                        end
                    end
                end
                ST_RD_ACK: begin
                    // Master ack continues with the next register
                    if (scl_rise) begin
                        if (sda) begin
                            state_d = ST_IDLE;
                        end else begin
                            ptr_d = ptr_q + 8'h01;
                        end
                    end
                    if (scl_fall && state_d == ST_RD_ACK) begin
                        state_d = ST_READ;
                        cnt_d   = 3'h0;
                        shift_d = rd_byte;
                        drive_d = ~rd_byte[7];
                        rstb_d  = 1'b1;
                    end
                end
            endcase
        end
        // Rstb fires at byte load; advance pointer after a write
        if (wstb_q) begin
            ptr_d = ptr_q + 8'h01;
        end
        // Command register write
        if (wstb_q && ptr_q == REG_CMD) begin
            ctl_d = {wdat_q[BIT_AMB_EN], wdat_q[BIT_NEAR_EN], wdat_q[BIT_SELF_EN]};
            if (!wdat_q[BIT_SELF_EN]) begin
                amb_ss_d  = amb_ss_d | wdat_q[BIT_AMB_SS];
                near_ss_d = near_ss_d | wdat_q[BIT_NEAR_SS];
            end
        end
    end

    // Register everything
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q    <= ST_IDLE;
            shift_q    <= 8'h00;
            cnt_q      <= 3'h0;
            rw_q       <= 1'b0;
            ptr_set_q  <= 1'b0;
            ptr_q      <= REG_FIRST;
            drive_q    <= 1'b0;
            wdat_q     <= 8'h00;
            wstb_q     <= 1'b0;
            rstb_q     <= 1'b0;
            ctl_q      <= 3'h0;
            amb_ss_q   <= 1'b0;
            near_ss_q  <= 1'b0;
            amb_rdy_q  <= 1'b0;
            near_rdy_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            shift_q    <= shift_d;
            cnt_q      <= cnt_d;
            rw_q       <= rw_d;
            ptr_set_q  <= ptr_set_d;
            ptr_q      <= ptr_d;
            drive_q    <= drive_d;
            wdat_q     <= wdat_d;
            wstb_q     <= wstb_d;
            rstb_q     <= rstb_d;
            ctl_q      <= ctl_d;
            amb_ss_q   <= amb_ss_d;
            near_ss_q  <= near_ss_d;
            amb_rdy_q  <= amb_rdy_d;
            near_rdy_q <= near_rdy_d;
        end
    end

    // Outputs; periodic runs only under self-timed mode
    assign o_sda              = 1'b0;
    assign o_sda_oe           = drive_q;
    assign o_reg_addr         = ptr_q;
    assign o_wr_data          = wdat_q;
    assign o_wr_stb           = wstb_q;
    assign o_rd_stb           = rstb_q;
    assign o_amb_single_shot  = amb_ss_q;
    assign o_near_single_shot = near_ss_q;
    assign o_self_timed       = ctl_q[0];
    assign o_amb_periodic     = ctl_q[0] & ctl_q[2];
    assign o_near_periodic    = ctl_q[0] & ctl_q[1];

    // Assertions
    sequence foreign_addr_s;
        state_q == ST_ADDR && scl_fall && cnt_q == 3'h7 && shift_q[7:1] != SLAVE_ADDR
            && !start && !stop;
    endsequence
    addr_filter_a: assert property (@(posedge i_clk) disable iff (i_reset)
        foreign_addr_s |=> state_q == ST_IDLE && !drive_q)
        else $error("foreign address was acknowledged");
    dir_bit_a: assert property (@(posedge i_clk) disable iff (i_reset)
        state_q == ST_ADDR_ACK && $changed(state_q) |-> rw_q == $past(shift_q[0]))
        else $error("direction bit not taken from address byte");
    range_wr_a: assert property (@(posedge i_clk) disable iff (i_reset)
        o_wr_stb |-> o_reg_addr >= REG_FIRST && o_reg_addr <= REG_LAST)
        else $error("write strobe outside register range");
    lock_bit_a: assert property (@(posedge i_clk) disable iff (i_reset)
        rstb_q && ptr_q == REG_CMD |-> shift_q[BIT_LOCK])
        else $error("lock bit not sent as one");
    amb_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
        amb_clr && !i_amb_done |=> !amb_rdy_q)
        else $error("ambient ready not cleared by result read");
    amb_set_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_amb_done |=> amb_rdy_q [*1])
        else $error("ambient ready not set by result");
    near_ready_a: assert property (@(posedge i_clk) disable iff (i_reset)
        near_clr && !i_near_done |=> !near_rdy_q)
        else $error("proximity ready not cleared");
    periodic_gate_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !o_self_timed |-> !o_amb_periodic && !o_near_periodic)
        else $error("periodic run without self timed");
    ss_ignore_a: assert property (@(posedge i_clk) disable iff (i_reset)
        wstb_q && ptr_q == REG_CMD && wdat_q[BIT_SELF_EN] && !amb_ss_q |=> !amb_ss_q)
        else $error("single shot taken during self timed");
    ptr_step_a: assert property (@(posedge i_clk) disable iff (i_reset)
        wstb_q |=> ptr_q == $past(ptr_q) + 8'h01)
        else $error("pointer did not advance after write");
endmodule // osic_port
`default_nettype wire

// file: test_optical_sensor_i2c_command_port.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_optical_sensor_i2c_command_port;
    import osic_pkg::*;
    logic       i_clk = 1'b0;
    logic       i_reset = 1'b1;
    logic       amb_done = 1'b0;
    logic       near_done = 1'b0;
    logic [7:0] rd_data = 8'h00;
    logic [7:0] rd_mask, wdat, got, wa, wd, reg_addr, wr_data;
    logic       scl_oe, sda_oe, dut_oe, dut_sda, ack, wr_stb, rd_stb;
    logic       a_ss, n_ss, a_per, n_per, self_on;
    wire        scl = !scl_oe;
    wire        sda = !sda_oe & (dut_oe ? dut_sda : 1'b1); // Pull-up when released
    int         err_count = 0, checks_done = 0, wr_cnt = 0, rd_cnt = 0, n;
    int         m_ardy, m_nrdy, m_ass, m_nss, m_aen, m_nen, m_self;
    // Clock
    always #2 i_clk = ~i_clk;
    osic_port dut (.i_clk(i_clk), .i_reset(i_reset), .i_scl(scl), .i_sda(sda),
        .o_sda(dut_sda), .o_sda_oe(dut_oe), .i_amb_done(amb_done), .i_near_done(near_done),
        .i_rd_data(rd_data), .o_reg_addr(reg_addr), .o_wr_data(wr_data), .o_wr_stb(wr_stb),
        .o_rd_stb(rd_stb), .o_amb_single_shot(a_ss), .o_near_single_shot(n_ss),
        .o_amb_periodic(a_per), .o_near_periodic(n_per), .o_self_timed(self_on));
    osic_host host (.i_clk(i_clk), .i_sda(sda), .o_scl_oe(scl_oe), .o_sda_oe(sda_oe));
    // Far-side result registers and strobe log
    always @(posedge i_clk) begin
        rd_data <= reg_addr ^ rd_mask;
        if (wr_stb === 1'b1) begin
            wr_cnt++;
            wa = reg_addr;
            wd = wr_data;
        end
        if (rd_stb === 1'b1) rd_cnt++;
    end
    function automatic logic [7:0] cmd_exp();
        return {1'b1, m_ardy[0], m_nrdy[0], m_ass[0], m_nss[0], m_aen[0], m_nen[0], m_self[0]};
    endfunction
    task automatic cmd_wr(input logic [7:0] d);
        logic [4:0] outs;
        host.wr(REG_CMD, d, ack);
        `CHK(ack, 1'b1)
        m_self = d[0];
        m_nen = d[1];
        m_aen = d[2];
        // Triggers only count while self-timed is off
        if (!d[0]) m_ass |= d[4];
        if (!d[0]) m_nss |= d[3];
        outs = {m_ass[0], m_nss[0], m_aen[0] & m_self[0], m_nen[0] & m_self[0], m_self[0]};
        `CHK({a_ss, n_ss, a_per, n_per, self_on}, outs)
        host.rd(REG_CMD, got);
        `CHK(got, cmd_exp())
    endtask
    task automatic done_pulse();
        amb_done <= 1'b1;
        near_done <= 1'b1;
        @(posedge i_clk);
        amb_done <= 1'b0;
        near_done <= 1'b0;
        m_ass = 0;
        m_nss = 0;
        m_ardy = 1;
        m_nrdy = 1;
        repeat (4) @(posedge i_clk);
        `CHK({a_ss, n_ss}, 2'b00)
        host.rd(REG_CMD, got);
        `CHK(got, cmd_exp())
    endtask
    task automatic res_rd(input logic [7:0] a);
        n = rd_cnt;
        host.rd(a, got);
        `CHK(got, a ^ rd_mask)
        `CHK(rd_cnt, n + 1)
        if (a < REG_NEAR_HI) m_ardy = 0;
        else m_nrdy = 0;
        host.rd(REG_CMD, got);
        `CHK(got, cmd_exp())
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (100000) @(posedge i_clk);
        err_count++;
        wrap_up();
    end
    // Main sequence
    initial begin
        rd_mask = $urandom(32'h32D45DAC);
        {m_ardy, m_nrdy, m_ass, m_nss, m_aen, m_nen, m_self} = '0;
        repeat (5) @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (5) @(posedge i_clk);
        host.rd(REG_CMD, got);
        `CHK(got, 8'h80)
        // Fast-mode write once; a full fast read would cost too many cycles
        host.half = 312;
        host.wr(REG_CMD, 8'h06, ack);
        host.half = 18;
        m_aen = 1;
        m_nen = 1;
        `CHK({ack, a_per, n_per}, 3'b100)
        cmd_wr(8'h19);
        cmd_wr(8'h18);
        done_pulse();
        for (int i = 0; i < 4; i++) begin
            cmd_wr(8'($urandom));
            done_pulse();
        end
        for (int a = REG_AMB_HI; a <= REG_NEAR_LO; a++) begin
            done_pulse();
            res_rd(8'(a));
        end
        wdat = 8'($urandom);
        host.wr(REG_LAST, wdat, ack);
        `CHK({wa, wd}, {REG_LAST, wdat})
        n = wr_cnt;
        host.wr(8'h91, wdat, ack);
        `CHK(wr_cnt, n)
        host.rd(8'h91, got);
        `CHK(got, 8'hFF)
        host.dev = 7'h12;
        host.wr(REG_CMD, 8'h07, ack);
        `CHK({ack, self_on}, {1'b0, m_self[0]})
        host.dev = SLAVE_ADDR;
        wrap_up();
    end
endmodule // test_optical_sensor_i2c_command_port
`default_nettype wire
